/* File: include/sbmc_pkg.sv */
/*
 Package for the sensor bus mode and configuration register bank: offsets,
 field positions, reset values, period tables and the register access struct.
 Assumes a single 40 MHz clock domain on the device side.
*/
package sbmc_pkg;

	// Register offsets.
	localparam logic [7:0] SBMC_OFS_NODE_ADDR = 8'h11;
	localparam logic [7:0] SBMC_OFS_BDIAG_CFG = 8'h12;
	localparam logic [7:0] SBMC_OFS_CR_CFG = 8'h13;
	localparam logic [7:0] SBMC_OFS_PER_EN = 8'h15;

	// Field positions.
	localparam int SBMC_NODE_ADDR_MSB = 3;
	localparam int SBMC_BDIAG_EN_BIT = 0;
	localparam int SBMC_TRAIN_RST_BIT = 4;
	localparam int SBMC_CR_PER_MSB = 3;
	localparam int SBMC_CR_PER_LSB = 2;
	localparam int SBMC_TRAIN_EN_BIT = 1;
	localparam int SBMC_SAMPLE_SEL_BIT = 0;
	localparam int SBMC_PER_EN_BIT = 7;

	// Reset values.
	localparam logic [7:0] SBMC_RST_NODE_ADDR = 8'h00;
	localparam logic [7:0] SBMC_RST_BDIAG_CFG = 8'h00;
	localparam logic [7:0] SBMC_RST_CR_CFG = 8'h00;
	localparam logic [7:0] SBMC_RST_PER_EN = 8'h00;

	// Writable bit masks; other bits read zero.
	localparam logic [7:0] SBMC_MSK_NODE_ADDR = 8'h0f;
	localparam logic [7:0] SBMC_MSK_BDIAG_CFG = 8'h01;
	localparam logic [7:0] SBMC_MSK_CR_CFG = 8'h1f;
	localparam logic [7:0] SBMC_MSK_PER_EN = 8'h80;

	// Periodic period in microseconds per code.
	localparam int SBMC_PER_US_0 = 500;
	localparam int SBMC_PER_US_1 = 125;
	localparam int SBMC_PER_US_2 = 250;
	localparam int SBMC_PER_US_3 = 333;
	localparam int SBMC_PER_US_4 = 500;
	localparam int SBMC_PER_US_5 = 1000;
	localparam int SBMC_PER_US_6 = 2000;
	localparam int SBMC_PER_US_7 = 4000;

	// Clock rate used to turn periods into cycle counts.
	localparam int SBMC_CLK_MHZ = 40;

	typedef enum logic [1:0]
	{
		SBMC_MODE_CMDRSP = 2'b00,
		SBMC_MODE_PERIODIC = 2'b01,
		SBMC_MODE_PER_DIAG = 2'b11
	} sbmc_mode_e;

	typedef enum logic [1:0]
	{
		SBMC_OSC_HOLD = 2'b00,
		SBMC_OSC_DEFAULT = 2'b01,
		SBMC_OSC_TRAIN = 2'b10
	} sbmc_osc_e;

	// One register access from the command decoder.
	typedef struct packed
	{
		logic wr;
		logic rd;
		logic [7:0] addr;
		logic [7:0] wdata;
	} sbmc_req_s;

endpackage : sbmc_pkg

/* File: rtl/sbmc_regs.sv */
/*
 Mode and configuration register bank of the sensor bus slave. Holds the node
 address shadow, background diagnostic enable, command/response configuration
 and the one-way periodic mode enable, and decodes them into mode controls.
 Assumes the command decoder on the same clock presents register accesses and
 the enter-periodic command as single-cycle strobes, and that OTP values are
 stable while rst_b is low and for the first cycle after its release.
*/
// Behaviour
// - Zero address: acquire address by discovery or command
// - Non-zero address: skip discovery, answer at it
// - Address writable; lock restores OTP value on reset
// - Address is bits 3:0 at 0x11
// - Shadow address covered by array check
// - 0x12 bit 0 enables background diagnostics
// - 0x13 holds training reset, period, enable, sample
// - Period code selects 1, 2, 4, 8 times
// - Period code used only for oscillator training
// - Training enabled: train oscillator from bus timing
// - Disabled, reset clear: hold last trained value
// - Disabled, reset set: return to default value
// - Sample select picks latency reference point
// - Periodic enable bit 7 at 0x15, two setters
// - Periodic enable cleared only by device reset
// - Enabling periodic locks registers, starts array check
// - Enable bits select active operating modes
// - Periodic code maps to its period table
`timescale 1ns/1ps
module sbmc_regs
	import sbmc_pkg::*;
#(
	parameter int CYC_W = 21
)
(
	// Clock and reset
	input wire logic mclk,
	input wire logic rst_b,
	// One-time-programmable values
	input wire logic [3:0] otp_node_addr,
	input wire logic otp_user_lock,
	input wire logic [2:0] periodic_period_code,
	// Register access from the command decoder
	input wire sbmc_req_s req,
	output logic [7:0] rdata,
	output logic rvalid,
	// Events from the command decoder
	input wire logic enter_periodic_cmd,
	input wire logic discovery_addr_valid,
	input wire logic [3:0] discovery_addr,
	// Decoded controls
	output logic [3:0] node_address,
	output logic discovery_participate,
	output logic command_response_active,
	output logic periodic_active,
	output logic background_diag_active,
	output logic config_locked,
	output logic array_check_start,
	output logic array_check_enable,
	output logic [7:0] array_check_sum,
	output sbmc_osc_e osc_training_state,
	output logic latency_from_cmd_edge,
	output logic [CYC_W-1:0] training_period_cycles
);

	// 4000 us at 40 MHz is 160000 cycles; the eight-fold multiplier needs 21 bits.
	initial
	begin
		if (CYC_W < 21 || CYC_W > 31)
			$error("sbmc_regs: CYC_W must lie in 21..31");
	end

	logic [3:0] addr_q;
	logic init_q;
	logic bdiag_en_q;
	logic [4:0] cr_cfg_q;
	logic per_en_q;
	logic per_en_d;
	logic per_en_prev_q;
	logic wr_ok;

	// Period in microseconds for the periodic code.
	function automatic int per_us(input logic [2:0] code);
		int r;
		r = SBMC_PER_US_0;
		unique case (code)
			3'h0: r = SBMC_PER_US_0;
			3'h1: r = SBMC_PER_US_1;
			3'h2: r = SBMC_PER_US_2;
			3'h3: r = SBMC_PER_US_3;
			3'h4: r = SBMC_PER_US_4;
			3'h5: r = SBMC_PER_US_5;
			3'h6: r = SBMC_PER_US_6;
			3'h7: r = SBMC_PER_US_7;
		endcase
		return r;
	endfunction : per_us

	// Configuration writes are refused once periodic mode has locked them.
	assign wr_ok = req.wr && !per_en_q;

	// Reset can only load a constant, so the OTP address is copied one cycle
	// after release. The copy is taken whether or not the user lock is set, so
	// a locked part always comes back at its programmed address.
	always_ff @(posedge mclk or negedge rst_b)
	begin
		if (!rst_b)
			init_q <= 1'b1;
		else
			init_q <= 1'b0;
	end

	always_ff @(posedge mclk or negedge rst_b)
	begin
		if (!rst_b)
			addr_q <= SBMC_RST_NODE_ADDR[3:0];
		else if (init_q)
			addr_q <= otp_node_addr;
		else if (wr_ok && req.addr == SBMC_OFS_NODE_ADDR)
			addr_q <= req.wdata[SBMC_NODE_ADDR_MSB:0];
		else if (discovery_addr_valid && addr_q == 4'h0)
			addr_q <= discovery_addr;
	end

	always_ff @(posedge mclk or negedge rst_b)
	begin
		if (!rst_b)
			bdiag_en_q <= SBMC_RST_BDIAG_CFG[SBMC_BDIAG_EN_BIT];
		else if (wr_ok && req.addr == SBMC_OFS_BDIAG_CFG)
			bdiag_en_q <= req.wdata[SBMC_BDIAG_EN_BIT];
	end

	always_ff @(posedge mclk or negedge rst_b)
	begin
		if (!rst_b)
			cr_cfg_q <= SBMC_RST_CR_CFG[4:0];
		else if (wr_ok && req.addr == SBMC_OFS_CR_CFG)
			cr_cfg_q <= req.wdata[4:0];
	end

	// Periodic enable is one-way: a written zero is ignored.
	always_comb
	begin
		per_en_d = per_en_q;
		if (enter_periodic_cmd)
			per_en_d = 1'b1;
		if (req.wr && req.addr == SBMC_OFS_PER_EN && req.wdata[SBMC_PER_EN_BIT])
			per_en_d = 1'b1;
	end

	always_ff @(posedge mclk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			per_en_q <= SBMC_RST_PER_EN[SBMC_PER_EN_BIT];
			per_en_prev_q <= 1'b0;
		end
		else
		begin
			per_en_q <= per_en_d;
			per_en_prev_q <= per_en_q;
		end
	end

	// Read data, registered; unmapped offsets read zero.
	always_ff @(posedge mclk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			rdata <= 8'h00;
			rvalid <= 1'b0;
		end
		else
		begin
			rvalid <= req.rd;
			rdata <= 8'h00;
			if (req.rd)
			begin
				unique case (req.addr)
					SBMC_OFS_NODE_ADDR: rdata <= {4'h0, addr_q} & SBMC_MSK_NODE_ADDR;
					SBMC_OFS_BDIAG_CFG: rdata <= {7'h00, bdiag_en_q} & SBMC_MSK_BDIAG_CFG;
					SBMC_OFS_CR_CFG: rdata <= {3'h0, cr_cfg_q} & SBMC_MSK_CR_CFG;
					SBMC_OFS_PER_EN: rdata <= {per_en_q, 7'h00} & SBMC_MSK_PER_EN;
					default: rdata <= 8'h00;
				endcase
			end
		end
	end

	// Oscillator training state.
	always_comb
	begin
		if (cr_cfg_q[SBMC_TRAIN_EN_BIT])
			osc_training_state = SBMC_OSC_TRAIN;
		else if (cr_cfg_q[SBMC_TRAIN_RST_BIT])
			osc_training_state = SBMC_OSC_DEFAULT;
		else
			osc_training_state = SBMC_OSC_HOLD;
	end

	// Expected command spacing for training; zero when training is off, since
	// command decoding never depends on it.
	always_comb
	begin
		logic [CYC_W-1:0] base;
		base = CYC_W'(per_us(periodic_period_code) * SBMC_CLK_MHZ);
		if (cr_cfg_q[SBMC_TRAIN_EN_BIT])
			training_period_cycles = base << cr_cfg_q[SBMC_CR_PER_MSB:SBMC_CR_PER_LSB];
		else
			training_period_cycles = '0;
	end

	assign node_address = addr_q;
	assign discovery_participate = (addr_q == 4'h0) && !per_en_q;
	assign command_response_active = !per_en_q;
	assign periodic_active = per_en_q;
	assign background_diag_active = per_en_q && bdiag_en_q;
	assign config_locked = per_en_q;
	assign array_check_start = per_en_q && !per_en_prev_q;
	assign array_check_enable = per_en_q;
	// Read/write array signature includes the address shadow.
	assign array_check_sum = {4'h0, addr_q} ^ {7'h00, bdiag_en_q} ^ {3'h0, cr_cfg_q}
		^ {per_en_q, 7'h00};
	assign latency_from_cmd_edge = cr_cfg_q[SBMC_SAMPLE_SEL_BIT];

endmodule : sbmc_regs

/* File: verification/sbmc_host.sv */
/* Register-access master model for the bank.
 Assumes one clock and a read answer one cycle after the request. */
`timescale 1ns/1ps
module sbmc_host
	import sbmc_pkg::*;
(
	// Bus
	input wire logic mclk,
	input wire logic [7:0] rdata,
	output sbmc_req_s req
);
	initial req = '0;
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge mclk) req <= '{1'b1, 1'b0, a, d};
		@(posedge mclk) req <= '0;
	endtask : wr
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge mclk) req <= '{1'b0, 1'b1, a, 8'h00};
		@(posedge mclk) req <= '0;
		#1 d = rdata;
	endtask : rd
endmodule : sbmc_host

/* File: verification/sbmc_asserts.sv */
/* Port checker for the bank.
 Assumes one clock domain with rst_b as its reset. */
`timescale 1ns/1ps
module sbmc_asserts
	import sbmc_pkg::*;
(
	// Clock and reset
	input wire logic mclk,
	input wire logic rst_b,
	// Ports watched
	input wire sbmc_req_s req,
	input wire logic [7:0] rdata,
	input wire logic rvalid,
	input wire logic [3:0] node_address,
	input wire logic command_response_active,
	input wire logic periodic_active,
	input wire logic background_diag_active,
	input wire logic config_locked,
	input wire logic array_check_start
);
	default clocking @(posedge mclk); endclocking
	default disable iff (!rst_b);
	sequence start_pulse_s;
		array_check_start ##1 !array_check_start;
	endsequence
	read_answer_a: assert property (req.rd |=> rvalid) else $error("no read answer");
	idle_data_a: assert property (!rvalid |-> rdata == 8'h00) else $error("idle data");
	enable_sticky_a: assert property (periodic_active |=> periodic_active) else $error("cleared");
	mode_select_a: assert property (command_response_active == !periodic_active) else $error("mode");
	diag_gate_a: assert property (background_diag_active |-> periodic_active) else $error("diag");
	check_start_a: assert property ($rose(periodic_active) |-> start_pulse_s) else $error("start");
	lock_follow_a: assert property (periodic_active |-> config_locked) else $error("unlocked");
	addr_write_a: assert property (req.wr && req.addr == SBMC_OFS_NODE_ADDR && !config_locked
		|=> node_address == $past(req.wdata[3:0])) else $error("address write");
endmodule : sbmc_asserts
bind sbmc_regs sbmc_asserts sbmc_asserts_inst (.mclk, .rst_b, .req, .rdata, .rvalid, .node_address,
	.command_response_active, .periodic_active, .background_diag_active, .config_locked,
	.array_check_start);

/* File: verification/sbmc_regs_tb.sv */
/* Self-checking bench for the bank.
 Assumes the host model drives every register access. */
`timescale 1ns/1ps
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin errors++; \
	$display("mismatch at %0t got %h exp %h", $time, g, e); end end
module sbmc_regs_tb
	import sbmc_pkg::*;
;
	typedef struct packed {logic [7:0] a; logic [7:0] d; logic [7:0] e; sbmc_osc_e o;} sbmc_row_s;
	localparam sbmc_row_s ROWS [7] = '{'{8'h11, 8'hff, 8'h0f, SBMC_OSC_HOLD},
		'{8'h12, 8'hff, 8'h01, SBMC_OSC_HOLD}, '{8'h13, 8'h12, 8'h12, SBMC_OSC_TRAIN},
		'{8'h13, 8'h10, 8'h10, SBMC_OSC_DEFAULT}, '{8'h13, 8'h00, 8'h00, SBMC_OSC_HOLD},
		'{8'h14, 8'hff, 8'h00, SBMC_OSC_HOLD}, '{8'h13, 8'h0f, 8'h0f, SBMC_OSC_TRAIN}};
	logic mclk = 1'b0, rst_b = 1'b0, epc = 1'b0, dav = 1'b0;
	logic [3:0] otp = 4'h0, da = 4'h0, node_address;
	logic [7:0] rdata, v;
	logic rvalid, dp, cra, pa, bda, lat, ace;
	logic [7:0] acs;
	sbmc_req_s req;
	sbmc_osc_e osc;
	logic [20:0] tpc;
	int errors = 0, samples_checked = 0;
	sbmc_regs sbmc_regs_inst (.mclk, .rst_b, .otp_node_addr(otp), .otp_user_lock(1'b1),
		.periodic_period_code(3'h1), .req, .rdata, .rvalid, .enter_periodic_cmd(epc),
		.discovery_addr_valid(dav), .discovery_addr(da), .node_address, .discovery_participate(dp),
		.command_response_active(cra), .periodic_active(pa), .background_diag_active(bda),
		.config_locked(), .array_check_start(), .array_check_enable(ace), .array_check_sum(acs),
		.osc_training_state(osc), .latency_from_cmd_edge(lat), .training_period_cycles(tpc));
	sbmc_host sbmc_host_inst (.mclk, .rdata, .req);
	initial forever #12.5 mclk = ~mclk;
	task automatic conclude;
		$display("checks %0d mismatches %0d", samples_checked, errors);
		if (errors == 0 && samples_checked > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : conclude
	task automatic rst_dut(input logic [3:0] a);
		@(posedge mclk);
		otp <= a;
		rst_b <= 1'b0;
		repeat (10) @(posedge mclk);
		rst_b <= 1'b1;
		repeat (2) @(posedge mclk);
		#1;
	endtask : rst_dut
	initial
	begin
		repeat (4000) @(posedge mclk);
		errors++;
		conclude();
	end
	initial
	begin
		rst_dut(4'h0);
		foreach (ROWS[i])
		begin
			sbmc_host_inst.wr(ROWS[i].a, ROWS[i].d);
			sbmc_host_inst.rd(ROWS[i].a, v);
			`CHK(v, ROWS[i].e)
			`CHK(osc, ROWS[i].o)
		end
		`CHK(tpc, 21'd40000)
		`CHK(lat, 1'b1)
		$display("register table test done");
		`CHK(ace, 1'b0)
		sbmc_host_inst.wr(8'h15, 8'h80);
		#1;
		`CHK({pa, bda, cra}, 3'b110)
		`CHK(ace, 1'b1)
		sbmc_host_inst.wr(8'h15, 8'h00);
		sbmc_host_inst.wr(8'h13, 8'h00);
		sbmc_host_inst.rd(8'h15, v);
		`CHK(v, 8'h80)
		sbmc_host_inst.rd(8'h13, v);
		`CHK(v, 8'h0f)
		$display("periodic enable test done");
		// The locked address must come back from the programmed copy, not the shadow.
		rst_dut(4'h5);
		`CHK({pa, cra, node_address, dp}, 7'h2a)
		`CHK(acs, 8'h05)
		rst_dut(4'h0);
		`CHK(dp, 1'b1)
		@(posedge mclk);
		dav <= 1'b1;
		da <= 4'h9;
		@(posedge mclk);
		dav <= 1'b0;
		@(posedge mclk);
		epc <= 1'b1;
		#1 `CHK(node_address, 4'h9)
		@(posedge mclk);
		epc <= 1'b0;
		#1 `CHK(pa, 1'b1)
		$display("reset and command test done");
		conclude();
	end
endmodule : sbmc_regs_tb
